// *** design/btc_regs.svh ***
/*
 offsets, field positions, fixed values and reset values of the bridge
 type-1 header front part; assumes byte addressing of configuration space
*/
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define BTC_OFS_CLASS_REV 8'h08
`define BTC_OFS_CACHE_LINE 8'h0C
`define BTC_OFS_LAT_TIMER 8'h0D
`define BTC_OFS_HEADER_KIND 8'h0E
`define BTC_OFS_SELF_TEST 8'h0F
`define BTC_OFS_CTL_BASE 8'h10
`define BTC_OFS_UP_BUS 8'h18
`define BTC_OFS_DOWN_BUS 8'h19
`define BTC_OFS_HIGH_BUS 8'h1A

// ************************************************************
// fixed field values
// ************************************************************
`define BTC_FUNCTION_CATEGORY 8'h06
`define BTC_SUBCATEGORY 8'h04
`define BTC_PROG_IF 8'h00
`define BTC_LAT_TIMER_VAL 8'h00
`define BTC_HEADER_KIND_VAL 8'h01
`define BTC_SELF_TEST_VAL 8'h00

// ************************************************************
// field positions
// ************************************************************
`define BTC_BASE_ADDR_LSB 12
`define BTC_BASE_LOW_BITS 12'h000
`define BTC_FULL_LANES 4'hF

// ************************************************************
// reset values
// ************************************************************
`define BTC_RST_CACHE_LINE 8'h00
`define BTC_RST_CTL_BASE 20'h00000
`define BTC_RST_BUS 8'h00

`endif

// *** design/btc_pkg.sv ***
/*
 types of the bridge type-1 header block;
 assumes btc_regs.svh sits beside it for the numbers
*/
package btc_pkg;
   // ************************************************************
   // access sequencer states, gray along idle -> answer
   // ************************************************************
   typedef enum logic [1:0] {
      BTC_IDLE = 2'b00,
      BTC_ANSWER = 2'b01
   } btc_state_t;

   // ************************************************************
   // all state of the header block
   // ************************************************************
   typedef struct packed {
      btc_state_t st;
      logic [7:0] cacheLineSize;
      logic [19:0] ctlBase;
      logic [7:0] upBus;
      logic [7:0] downBus;
      logic [7:0] highBus;
      logic [31:0] rdData;
      logic ack;
      logic pwInvalidate;
      logic pwDone;
      logic t1ToType0;
      logic t1ToType1;
      logic t1Unclaimed;
      logic t1Done;
   } btc_state_vec_t;
endpackage

// *** design/btc_mwi_check.sv ***
/*
 combinational test of a posted write against memory write invalidate
 conditions; assumes the line size counts dwords and enables are active high
*/
`timescale 1ns/10ps
`default_nettype none
`include "btc_regs.svh"

module btc_mwi_check
   import btc_pkg::*;
(
   // programmed settings
   input wire logic [7:0] lineSize,
   input wire logic invalidateOn,
   // posted write
   input wire logic [31:0] wrAddr,
   input wire logic [10:0] wrDwords,
   input wire logic [3:0] firstLanes,
   input wire logic [3:0] lastLanes,
   // verdict
   output logic useInvalidate
);
   logic sizeOk;
   logic alignOk;
   logic lengthOk;
   logic lanesOk;
   logic [7:0] lineMask;

   always_comb begin
      lineMask = lineSize - 8'h01;
      sizeOk = $onehot(lineSize);
      // byte address bits below the dword must be zero; line counts dwords
      alignOk = ((wrAddr[9:2] & lineMask) == 8'h00) && (wrAddr[1:0] == 2'h0);
      lengthOk = wrDwords >= {3'h0, lineSize};
      lanesOk = (firstLanes == `BTC_FULL_LANES) && (lastLanes == `BTC_FULL_LANES);
      // plain memory write unless every condition holds
      useInvalidate = sizeOk && alignOk && lengthOk && lanesOk && invalidateOn;
   end
endmodule
`default_nettype wire

// *** design/btc_config_header.sv ***
/*
 front part of a bridge type-1 configuration header (08h..1Ah), posted
 write command selection and type 1 configuration routing; assumes
 requests come from upstream logic on mclk, one at a time per port
*/
// Functional notes
// - class bits 31:24 read 06h, bridge; writes ignored
// - class bits 23:16 read 04h, bridge to bridge subcategory
// - programming interface byte 15:8 reads zero, read only
// - bits 7:0 report the fixed silicon revision, read only
// - posted writes go out as memory write unless invalidate fits
// - invalidate only with line size a power of two, 1 to 128
// - invalidate only when the write starts on a line boundary
// - invalidate only when the write covers a whole line
// - invalidate only when first and last words enable all lanes
// - invalidate only while the invalidate enable is on
// - upstream latency timer byte at 0Dh reads zero
// - header kind byte at 0Eh reads 01h, single function
// - self test byte at 0Fh reads zero
// - window base bits 31:12 decode a 4K aligned window
// - base bits 31:12 read zero and refuse writes while gated off
// - base bits 31:12 take writes while the write enable is set
// - base bits 11:4 read zero, bit 3 zero non-prefetchable
// - base bits 2:1 read 00b, bit 0 zero marks memory space
// - byte 18h holds the upstream bus number, resets to zero
// - byte 19h holds the downstream bus number, resets to zero
// - byte 1Ah holds the highest downstream bus, resets to zero
`timescale 1ns/10ps
`default_nettype none
`include "btc_regs.svh"

module btc_config_header
   import btc_pkg::*;
#(
   parameter logic [7:0] SILICON_REVISION = 8'h00 // value is arbitrary
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // configuration access
   input wire logic cfgValid,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgAck,
   output logic cfgHit,
   // settings kept elsewhere in the header
   input wire logic controlWindowWriteEnable,
   input wire logic invalidateEnable,
   // posted write classification
   input wire logic pwValid,
   input wire logic [31:0] pwAddr,
   input wire logic [10:0] pwDwords,
   input wire logic [3:0] pwFirstBe,
   input wire logic [3:0] pwLastBe,
   output logic pwInvalidate,
   output logic pwDone,
   // type 1 configuration routing
   input wire logic t1Valid,
   input wire logic [7:0] t1Bus,
   output logic t1ToType0,
   output logic t1ToType1,
   output logic t1Unclaimed,
   output logic t1Done,
   // control window decode
   input wire logic [31:0] memAddr,
   output logic ctlWindowHit,
   output logic [31:0] ctlWindowBase
);
   btc_state_vec_t s_reg;
   btc_state_vec_t s_next;
   logic mwiFits;

   // ************************************************************
   // read value of one dword of the header
   // ************************************************************
   function automatic logic [31:0] readDword(input logic [7:0] addr, input btc_state_vec_t s,
      input logic baseOpen);
      logic [31:0] d;
      d = 32'h00000000;
      case ({addr[7:2], 2'b00})
         `BTC_OFS_CLASS_REV:
            d = {`BTC_FUNCTION_CATEGORY, `BTC_SUBCATEGORY, `BTC_PROG_IF,
               SILICON_REVISION};
         `BTC_OFS_CACHE_LINE:
            d = {`BTC_SELF_TEST_VAL, `BTC_HEADER_KIND_VAL,
               `BTC_LAT_TIMER_VAL, s.cacheLineSize};
         `BTC_OFS_CTL_BASE:
            // gated off, the base reads zero yet keeps what was written
            d = {s.ctlBase & {20{baseOpen}}, `BTC_BASE_LOW_BITS};
         `BTC_OFS_UP_BUS:
            d = {8'h00, s.highBus, s.downBus, s.upBus};
         default:
            d = 32'h00000000;
      endcase
      return d;
   endfunction

   // ************************************************************
   // whether an address falls in the header front part
   // ************************************************************
   function automatic logic isMapped(input logic [7:0] addr);
      logic [7:0] a;
      a = {addr[7:2], 2'b00};
      return (a == `BTC_OFS_CLASS_REV) || (a == `BTC_OFS_CACHE_LINE) ||
         (a == `BTC_OFS_CTL_BASE) || (a == `BTC_OFS_UP_BUS);
   endfunction

   btc_mwi_check u_mwi (
      .lineSize(s_reg.cacheLineSize),
      .invalidateOn(invalidateEnable),
      .wrAddr(pwAddr),
      .wrDwords(pwDwords),
      .firstLanes(pwFirstBe),
      .lastLanes(pwLastBe),
      .useInvalidate(mwiFits)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      s_next.ack = 1'b0;
      s_next.pwDone = 1'b0;
      s_next.t1Done = 1'b0;
      case (s_reg.st)
         BTC_IDLE: begin
            if (cfgValid) begin
               s_next.st = BTC_ANSWER;
               s_next.ack = 1'b1;
               s_next.rdData = cfgWrite ? 32'h00000000 :
                  readDword(cfgAddr, s_reg, controlWindowWriteEnable);
               if (cfgWrite) begin
                  // class, timer, kind and self test bytes ignore writes
                  case ({cfgAddr[7:2], 2'b00})
                     `BTC_OFS_CACHE_LINE: begin
                        if (cfgByteEn[0]) begin
                           s_next.cacheLineSize = cfgWrData[7:0];
                        end
                     end
                     `BTC_OFS_CTL_BASE: begin
                        if (controlWindowWriteEnable) begin
                           if (cfgByteEn[1]) begin
                              s_next.ctlBase[3:0] = cfgWrData[15:12];
                           end
                           if (cfgByteEn[2]) begin
                              s_next.ctlBase[11:4] = cfgWrData[23:16];
                           end
                           if (cfgByteEn[3]) begin
                              s_next.ctlBase[19:12] = cfgWrData[31:24];
                           end
                        end
                     end
                     `BTC_OFS_UP_BUS: begin
                        if (cfgByteEn[0]) begin
                           s_next.upBus = cfgWrData[7:0];
                        end
                        if (cfgByteEn[1]) begin
                           s_next.downBus = cfgWrData[15:8];
                        end
                        if (cfgByteEn[2]) begin
                           s_next.highBus = cfgWrData[23:16];
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         BTC_ANSWER: begin
            // one answer cycle between accesses keeps a held request from repeating
            s_next.st = BTC_IDLE;
         end
         default: begin
            s_next.st = BTC_IDLE;
         end
      endcase
      if (pwValid) begin
         s_next.pwInvalidate = mwiFits;
         s_next.pwDone = 1'b1;
      end
      if (t1Valid) begin
         s_next.t1ToType0 = t1Bus == s_reg.downBus;
         s_next.t1ToType1 = (t1Bus > s_reg.downBus) && (t1Bus <= s_reg.highBus);
         s_next.t1Unclaimed = !((t1Bus >= s_reg.downBus) && (t1Bus <= s_reg.highBus));
         s_next.t1Done = 1'b1;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_reg <= '{st: BTC_IDLE, cacheLineSize: `BTC_RST_CACHE_LINE,
            ctlBase: `BTC_RST_CTL_BASE, upBus: `BTC_RST_BUS, downBus: `BTC_RST_BUS,
            highBus: `BTC_RST_BUS, rdData: 32'h00000000, default: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign cfgRdData = s_reg.rdData;
   assign cfgAck = s_reg.ack;
   assign cfgHit = isMapped(cfgAddr);
   assign pwInvalidate = s_reg.pwInvalidate;
   assign pwDone = s_reg.pwDone;
   assign t1ToType0 = s_reg.t1ToType0;
   assign t1ToType1 = s_reg.t1ToType1;
   assign t1Unclaimed = s_reg.t1Unclaimed;
   assign t1Done = s_reg.t1Done;
   // window is 4K; an all-zero base is treated as unassigned
   assign ctlWindowBase = {s_reg.ctlBase, `BTC_BASE_LOW_BITS};
   assign ctlWindowHit = (s_reg.ctlBase != 20'h00000) &&
      (memAddr[31:`BTC_BASE_ADDR_LSB] == s_reg.ctlBase);

   // ************************************************************
   // checks
   // ************************************************************
   a_class_fixed: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h02
      |=> cfgAck && cfgRdData[31:8] == 24'h060400)
      else $error("class bytes wrong");

   a_rev_read: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h02
      |=> cfgRdData[7:0] == SILICON_REVISION)
      else $error("revision byte wrong");

   a_hdr_fixed: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h03
      |=> cfgRdData[31:8] == 24'h000100 && cfgRdData[7:0] == s_reg.cacheLineSize)
      else $error("header kind dword wrong");

   a_base_gated: assert property (@(posedge mclk) disable iff (reset)
      !controlWindowWriteEnable |=> $stable(s_reg.ctlBase))
      else $error("base changed while gated");

   a_base_write: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h04 &&
      controlWindowWriteEnable && cfgByteEn == 4'hF
      |=> ctlWindowBase == {$past(cfgWrData[31:12]), 12'h000})
      else $error("base write lost");

   a_base_low: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h04
      |=> cfgRdData[11:0] == 12'h000)
      else $error("base low bits not zero");

   a_bus_write: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h06 && cfgByteEn[1]
      |=> s_reg.downBus == $past(cfgWrData[15:8]))
      else $error("downstream bus write lost");

   a_mwi_off: assert property (@(posedge mclk) disable iff (reset)
      pwValid && !invalidateEnable |=> pwDone && !pwInvalidate)
      else $error("invalidate while disabled");

   a_mwi_size: assert property (@(posedge mclk) disable iff (reset)
      pwValid && !$onehot(s_reg.cacheLineSize) |=> !pwInvalidate)
      else $error("invalidate with bad line size");

   a_mwi_lanes: assert property (@(posedge mclk) disable iff (reset)
      pwValid && (pwFirstBe != 4'hF || pwLastBe != 4'hF) |=> !pwInvalidate)
      else $error("invalidate with partial lanes");

   a_t1_route: assert property (@(posedge mclk) disable iff (reset)
      t1Valid && t1Bus == s_reg.downBus |=> t1Done && t1ToType0 && !t1ToType1)
      else $error("type 1 routing wrong");

   a_t1_forward: assert property (@(posedge mclk) disable iff (reset)
      t1Valid && t1Bus > s_reg.downBus && t1Bus <= s_reg.highBus
      |=> t1ToType1 && !t1ToType0 && !t1Unclaimed)
      else $error("type 1 forward wrong");

   a_t1_outside: assert property (@(posedge mclk) disable iff (reset)
      t1Valid && (t1Bus < s_reg.downBus || t1Bus > s_reg.highBus)
      |=> t1Unclaimed && !t1ToType1)
      else $error("type 1 outside claimed");

   a_sub_class: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h02
      |=> cfgRdData[23:16] == 8'h04)
      else $error("subcategory byte wrong");

   a_prog_if: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h02
      |=> cfgRdData[15:8] == 8'h00)
      else $error("programming interface byte wrong");

   a_lat_zero: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h03
      |=> cfgRdData[15:8] == 8'h00)
      else $error("latency timer byte not zero");

   a_self_test: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h03
      |=> cfgRdData[31:24] == 8'h00)
      else $error("self test byte not zero");

   a_base_hidden: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h04 &&
      !controlWindowWriteEnable |=> cfgRdData[31:12] == 20'h00000)
      else $error("gated base not read as zero");

   a_base_kind: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && !cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h04
      |=> cfgRdData[3:0] == 4'h0)
      else $error("base type bits not zero");

   a_window_hit: assert property (@(posedge mclk) disable iff (reset)
      ctlWindowHit |-> memAddr[31:12] == ctlWindowBase[31:12])
      else $error("window hit outside the 4K window");

   a_up_write: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h06 && cfgByteEn[0]
      |=> s_reg.upBus == $past(cfgWrData[7:0]))
      else $error("upstream bus write lost");

   a_high_write: assert property (@(posedge mclk) disable iff (reset)
      cfgValid && cfgWrite && s_reg.st == BTC_IDLE && cfgAddr[7:2] == 6'h06 && cfgByteEn[2]
      |=> s_reg.highBus == $past(cfgWrData[23:16]))
      else $error("highest bus write lost");

   a_mwi_align: assert property (@(posedge mclk) disable iff (reset)
      pwValid && (pwAddr[1:0] != 2'h0 ||
      (pwAddr[9:2] & (s_reg.cacheLineSize - 8'h01)) != 8'h00) |=> !pwInvalidate)
      else $error("invalidate off a line boundary");

   a_mwi_length: assert property (@(posedge mclk) disable iff (reset)
      pwValid && pwDwords < {3'h0, s_reg.cacheLineSize} |=> !pwInvalidate)
      else $error("invalidate shorter than a line");

   a_pw_answer: assert property (@(posedge mclk) disable iff (reset)
      pwValid |=> pwDone)
      else $error("posted write not classified");
endmodule
`default_nettype wire

// *** tb/btc_cfg_host.sv ***
/*
 upstream requester model issuing configuration reads and writes;
 assumes the block answers each taken request with a one-cycle ack
*/
`timescale 1ns/10ps
`default_nettype none

module btc_cfg_host (
   // clock
   input wire logic mclk,
   // request
   output logic cfgValid,
   output logic cfgWrite,
   output logic [7:0] cfgAddr,
   output logic [3:0] cfgByteEn,
   output logic [31:0] cfgWrData,
   // answer
   input wire logic [31:0] cfgRdData,
   input wire logic cfgAck,
   input wire logic cfgHit
);
   initial begin
      cfgValid = 1'b0;
      cfgWrite = 1'b0;
      cfgAddr = 8'h00;
      cfgByteEn = 4'h0;
      cfgWrData = 32'h00000000;
   end

   // ************************************************************
   // one access, held until the ack shows
   // ************************************************************
   task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] rd, output logic ok, output logic hit);
      int n;
      @(negedge mclk);
      cfgValid = 1'b1;
      cfgWrite = wr;
      cfgAddr = a;
      cfgByteEn = be;
      cfgWrData = d;
      ok = 1'b0;
      rd = 32'h00000000;
      hit = 1'b0;
      for (n = 0; n < 8 && !ok; n++) begin
         @(negedge mclk);
         if (cfgAck === 1'b1) begin
            ok = 1'b1;
            rd = cfgRdData;
            hit = cfgHit;
         end
      end
      // hold through the edge that samples the ack; the answer cycle ignores it
      if (ok) begin
         @(negedge mclk);
      end
      // released fields flip so a stale value never passes for a fresh one
      cfgValid = 1'b0;
      cfgWrite = ~cfgWrite;
      cfgAddr = ~cfgAddr;
      cfgByteEn = ~cfgByteEn;
      cfgWrData = ~cfgWrData;
   endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
/*
 self-checking bench of the bridge type-1 header front part;
 assumes one 20 MHz clock and the requester model beside it
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
   localparam logic [7:0] REV = 8'h5A; // value is arbitrary
   localparam int LIMIT = 4000;
   logic mclk, reset, cfgValid, cfgWrite, cfgAck, cfgHit, wen, invEn;
   logic [7:0] cfgAddr, t1Bus;
   logic [3:0] cfgByteEn, pwFirstBe, pwLastBe;
   logic [31:0] cfgWrData, cfgRdData, pwAddr, memAddr, ctlWindowBase, rdv;
   logic [10:0] pwDwords;
   logic pwValid, pwInvalidate, pwDone, t1Valid, t1ToType0, t1ToType1, t1Unclaimed;
   logic t1Done, ctlWindowHit, okv, hitv;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;

   btc_config_header #(.SILICON_REVISION(REV)) dut (.mclk(mclk), .reset(reset),
      .cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
      .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgAck(cfgAck), .cfgHit(cfgHit),
      .controlWindowWriteEnable(wen), .invalidateEnable(invEn), .pwValid(pwValid),
      .pwAddr(pwAddr), .pwDwords(pwDwords), .pwFirstBe(pwFirstBe), .pwLastBe(pwLastBe),
      .pwInvalidate(pwInvalidate), .pwDone(pwDone), .t1Valid(t1Valid), .t1Bus(t1Bus),
      .t1ToType0(t1ToType0), .t1ToType1(t1ToType1), .t1Unclaimed(t1Unclaimed),
      .t1Done(t1Done), .memAddr(memAddr), .ctlWindowHit(ctlWindowHit),
      .ctlWindowBase(ctlWindowBase));

   btc_cfg_host host (.mclk(mclk), .cfgValid(cfgValid), .cfgWrite(cfgWrite),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .cfgAck(cfgAck), .cfgHit(cfgHit));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
      logic mapped;
      mapped = a[7:2] inside {6'h02, 6'h03, 6'h04, 6'h06};
      host.access(wr, a, be, d, rdv, okv, hitv);
      check("cfg ack", {31'h0, okv}, 32'h1);
      check("cfg hit", {31'h0, hitv}, {31'h0, mapped});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      cfg(1'b0, a, 4'h0, 32'h0);
      check("cfg read", rdv, exp);
   endtask

   task automatic pw_case(input logic [7:0] ls, input logic [31:0] a, input logic [10:0] n,
      input logic [3:0] fb, input logic [3:0] lb, input logic en, input logic exp);
      cfg(1'b1, 8'h0C, 4'h1, {24'h0, ls});
      @(negedge mclk);
      invEn = en;
      pwValid = 1'b1;
      pwAddr = a;
      pwDwords = n;
      pwFirstBe = fb;
      pwLastBe = lb;
      @(negedge mclk);
      pwValid = 1'b0;
      check("pw done", {31'h0, pwDone}, 32'h1);
      check("pw invalidate", {31'h0, pwInvalidate}, {31'h0, exp});
   endtask

   task automatic t1_case(input logic [7:0] b, input logic [2:0] exp);
      @(negedge mclk);
      t1Valid = 1'b1;
      t1Bus = b;
      @(negedge mclk);
      t1Valid = 1'b0;
      check("t1 done", {31'h0, t1Done}, 32'h1);
      check("t1 verdict", {29'h0, t1ToType0, t1ToType1, t1Unclaimed}, {29'h0, exp});
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic test_reset_values();
      rdchk(8'h08, {8'h06, 8'h04, 8'h00, REV});
      rdchk(8'h0C, 32'h00010000);
      rdchk(8'h10, 32'h00000000);
      rdchk(8'h18, 32'h00000000);
   endtask

   task automatic test_read_only();
      cfg(1'b1, 8'h08, 4'hF, 32'hFFFFFFFF);
      rdchk(8'h08, {8'h06, 8'h04, 8'h00, REV});
      cfg(1'b1, 8'h0C, 4'hF, 32'hFFFFFFFF);
      rdchk(8'h0C, 32'h000100FF);
      cfg(1'b1, 8'h14, 4'hF, 32'hFFFFFFFF);
      rdchk(8'h14, 32'h00000000);
   endtask

   task automatic test_window();
      cfg(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF);
      rdchk(8'h10, 32'h00000000);
      @(negedge mclk);
      wen = 1'b1;
      cfg(1'b1, 8'h10, 4'hF, 32'hABCDEFFF);
      rdchk(8'h10, 32'hABCDE000);
      check("window base", ctlWindowBase, 32'hABCDE000);
      memAddr = 32'hABCDEFFC;
      #1 check("window hit", {31'h0, ctlWindowHit}, 32'h1);
      memAddr = 32'hABCDF000;
      #1 check("window miss", {31'h0, ctlWindowHit}, 32'h0);
      // lane 1 reaches only bits 15:12 of the base
      cfg(1'b1, 8'h10, 4'h2, 32'h0000FFFF);
      rdchk(8'h10, 32'hABCDF000);
      @(negedge mclk);
      wen = 1'b0;
      cfg(1'b1, 8'h10, 4'hF, 32'h12345000);
      rdchk(8'h10, 32'h00000000);
      check("window kept", ctlWindowBase, 32'hABCDF000);
   endtask

   task automatic test_bus_numbers();
      cfg(1'b1, 8'h18, 4'h7, 32'hFF080502);
      rdchk(8'h18, 32'h00080502);
      cfg(1'b1, 8'h18, 4'h2, 32'hFFFF06FF);
      rdchk(8'h18, 32'h00080602);
      cfg(1'b1, 8'h18, 4'h2, 32'h00000500);
      rdchk(8'h18, 32'h00080502);
   endtask

   task automatic test_posted();
      pw_case(8'h10, 32'h00000040, 11'h010, 4'hF, 4'hF, 1'b1, 1'b1);
      pw_case(8'h0C, 32'h00000040, 11'h010, 4'hF, 4'hF, 1'b1, 1'b0);
      pw_case(8'h00, 32'h00000040, 11'h010, 4'hF, 4'hF, 1'b1, 1'b0);
      pw_case(8'h80, 32'h00000200, 11'h080, 4'hF, 4'hF, 1'b1, 1'b1);
      pw_case(8'h01, 32'h00000004, 11'h001, 4'hF, 4'hF, 1'b1, 1'b1);
      pw_case(8'h10, 32'h00000044, 11'h010, 4'hF, 4'hF, 1'b1, 1'b0);
      pw_case(8'h10, 32'h00000040, 11'h00F, 4'hF, 4'hF, 1'b1, 1'b0);
      pw_case(8'h10, 32'h00000040, 11'h010, 4'hE, 4'hF, 1'b1, 1'b0);
      pw_case(8'h10, 32'h00000040, 11'h010, 4'hF, 4'h7, 1'b1, 1'b0);
      pw_case(8'h10, 32'h00000040, 11'h010, 4'hF, 4'hF, 1'b0, 1'b0);
   endtask

   task automatic test_routing();
      t1_case(8'h05, 3'b100);
      t1_case(8'h06, 3'b010);
      t1_case(8'h08, 3'b010);
      t1_case(8'h09, 3'b001);
      t1_case(8'h04, 3'b001);
   endtask

   // ************************************************************
   // verdict, clock, timeout, main sequence
   // ************************************************************
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // a hung handshake stops here instead of running on
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      reset = 1'b1;
      wen = 1'b0;
      invEn = 1'b0;
      pwValid = 1'b0;
      pwAddr = 32'h00000000;
      pwDwords = 11'h000;
      pwFirstBe = 4'h0;
      pwLastBe = 4'h0;
      t1Valid = 1'b0;
      t1Bus = 8'h00;
      memAddr = 32'h00000000;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      test_reset_values();
      test_read_only();
      test_window();
      test_bus_numbers();
      test_posted();
      test_routing();
      print_verdict();
   end
endmodule

`default_nettype wire
